// >>> sdl_regs.svh
// Timing constants and field values for the single-pin debug link
`ifndef SDL_REGS_SVH
`define SDL_REGS_SVH

`define SDL_CLK_MHZ          125
`define SDL_CAL_CHAR         8'h80
`define SDL_BRK_OPCODE       8'h00
`define SDL_CAL_LOW_BITS     8
`define SDL_BREAK_BITS       9
`define SDL_MIN_RATE_DIV     512
`define SDL_CNT_W            16
`define SDL_ERR_BREAK_CHARS  4
`define SDL_CHAR_BITS        10
`define SDL_DBG_BIT          0
`define SDL_BPEN_BIT         1

`endif

// >>> sdl_pkg.sv
// Types shared by the single-pin debug link
package sdl_pkg;
    typedef enum logic [4:0] {
        SDL_IDLE  = 5'h01,
        SDL_START = 5'h02,
        SDL_DATA  = 5'h04,
        SDL_STOP  = 5'h08,
        SDL_BRKTX = 5'h10
    } sdl_txs_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sdl_byte_t;

    typedef struct packed {
        logic breakpoint_opcode;
        logic frame;
        logic coll;
    } sdl_err_t;
endpackage

// >>> sdl_baud.sv
// Auto-baud detector and bit-rate generator
`timescale 1ns/1ns
`include "sdl_regs.svh"
module sdl_baud (
    // Clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    // Line and control
    input  wire logic                    line_i,
    input  wire logic                    recal_i,
    // Result
    output logic                         locked_o,
    output logic [`SDL_CNT_W-1:0]        bit_len_o
);
    logic                  locked, next_locked;
    logic                  meas, next_meas;
    logic [`SDL_CNT_W-1:0] cnt, next_cnt;
    logic [`SDL_CNT_W-1:0] len, next_len;

    // ==========================================
    // Measure the 8-bit low interval of 80H
    always_comb begin
        next_locked = locked;
        next_meas   = meas;
        next_cnt    = cnt;
        next_len    = len;
        if (recal_i) begin
            next_locked = 1'b0;
            next_meas   = 1'b0;
            next_cnt    = '0;
        end else if (!locked) begin
            if (!line_i) begin
                next_meas = 1'b1;
                if (cnt != {`SDL_CNT_W{1'b1}})
                    next_cnt = cnt + 1'b1;
            end else if (meas) begin
                // Eight bit times low; divide by eight, 512 clocks/bit fits
                next_len    = (cnt >> 3 == 0) ? `SDL_CNT_W'(1) : cnt >> 3;
                next_locked = 1'b1;
                next_meas   = 1'b0;
                next_cnt    = '0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            locked <= 1'b0;
            meas   <= 1'b0;
            cnt    <= '0;
            len    <= `SDL_CNT_W'(1);
        end else begin
            locked <= next_locked;
            meas   <= next_meas;
            cnt    <= next_cnt;
            len    <= next_len;
        end
    end

    assign locked_o  = locked;
    assign bit_len_o = len;
endmodule // sdl_baud

// >>> sdl_rx.sv
// Serial receiver with break and framing detection
`timescale 1ns/1ns
`include "sdl_regs.svh"
module sdl_rx (
    // Clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    // Line and timing
    input  wire logic                    line_i,
    input  wire logic                    enable_i,
    input  wire logic [`SDL_CNT_W-1:0]   bit_len_i,
    // Results
    output sdl_pkg::sdl_byte_t           byte_o,
    output logic                         frame_err_o,
    output logic                         break_o
);
    logic                  busy, next_busy;
    logic [3:0]            bitn, next_bitn;
    logic [`SDL_CNT_W-1:0] tmr, next_tmr;
    logic [7:0]            shf, next_shf;
    logic [`SDL_CNT_W+3:0] low, next_low;
    sdl_pkg::sdl_byte_t    ob, next_ob;
    logic                  fe, next_fe;

    // ==========================================
    // Sample at bit centres
    always_comb begin
        next_busy = busy;
        next_bitn = bitn;
        next_tmr  = tmr;
        next_shf  = shf;
        next_ob   = '0;
        next_fe   = 1'b0;
        next_low  = line_i ? '0 : low + 1'b1;
        if (!enable_i) begin
            next_busy = 1'b0;
        end else if (!busy) begin
            if (!line_i) begin
                next_busy = 1'b1;
                next_bitn = '0;
                next_tmr  = bit_len_i >> 1;
            end
        end else if (tmr != 0) begin
            next_tmr = tmr - 1'b1;
        end else begin
            next_tmr  = bit_len_i - 1'b1;
            next_bitn = bitn + 1'b1;
            if (bitn >= 4'd1 && bitn <= 4'd8)
                next_shf = {line_i, shf[7:1]};
            if (bitn == 4'd9) begin
                next_busy = 1'b0;
                if (!line_i)
                    next_fe = 1'b1;
                else
                    next_ob = '{valid: 1'b1, data: shf};
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy <= 1'b0;
            bitn <= '0;
            tmr  <= '0;
            shf  <= '0;
            low  <= '0;
            ob   <= '0;
            fe   <= 1'b0;
        end else begin
            busy <= next_busy;
            bitn <= next_bitn;
            tmr  <= next_tmr;
            shf  <= next_shf;
            low  <= next_low;
            ob   <= next_ob;
            fe   <= next_fe;
        end
    end

    // Break: nine or more bit times low
    assign break_o     = enable_i && !line_i
                         && (low >= `SDL_BREAK_BITS * {4'h0, bit_len_i});
    assign byte_o      = ob;
    assign frame_err_o = fe;
endmodule // sdl_rx

// >>> sdl_port.sv
// Single-pin debug port: link, error handling and debug-mode control
// ==========================================
`timescale 1ns/1ns
`include "sdl_regs.svh"
module sdl_port (
    // Clock and reset (reset covers power-on, brownout and reset pin)
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Debug serial pin, open drain
    input  wire logic        debug_serial_pin_i,
    output logic             debug_serial_pin_o,
    output logic             debug_serial_pin_oe_o,
    // Command controller side
    output sdl_pkg::sdl_byte_t rx_byte_o,
    input  wire logic        tx_valid_i,
    input  wire logic [7:0]  tx_data_i,
    output logic             tx_ready_o,
    output logic             cmd_abort_o,
    // Debug control register writes from the command controller
    input  wire logic        ctl_we_i,
    input  wire logic [7:0]  ctl_wdata_i,
    output logic [7:0]       ctl_o,
    // CPU side
    input  wire logic        cpu_brk_decode_i,
    input  wire logic [7:0]  cpu_opcode_i,
    input  wire logic        watch_match_i,
    input  wire logic        stop_mode_i,
    output logic             debug_mode_flag_o,
    output logic             cpu_fetch_stop_o,
    output logic             brk_as_nop_o,
    output logic             halt_exit_o,
    output logic             wdt_refresh_o,
    output logic             sys_reset_req_o,
    output sdl_pkg::sdl_err_t err_o
);
    // ==========================================
    // Pin synchroniser
    logic pin_s1, pin_s2;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end else begin
            pin_s1 <= debug_serial_pin_i;
            pin_s2 <= pin_s1;
        end
    end

    // ==========================================
    // Break hold: link logic kept in reset until pin high again
    logic                  in_break, next_in_break;
    logic                  rx_brk;
    logic                  locked;
    logic [`SDL_CNT_W-1:0] bit_len;
    logic                  rx_fe;
    sdl_pkg::sdl_txs_t     txs, next_txs;
    logic                  recal;
    logic                  err_any;
    logic                  coll, next_coll;

    always_comb begin
        next_in_break = in_break;
        // Own error break holds the port too, so no rate is learnt from it
        if (rx_brk || txs == sdl_pkg::SDL_BRKTX)
            next_in_break = 1'b1;
        else if (pin_s2)
            next_in_break = 1'b0;
    end

    // Rate detector restarts on any error
    assign recal = in_break || rx_brk || err_any || txs == sdl_pkg::SDL_BRKTX;

    sdl_baud u_baud (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .line_i    (pin_s2),
        .recal_i   (recal),
        .locked_o  (locked),
        .bit_len_o (bit_len)
    );

    // Receiver disabled while sending keeps the link half-duplex
    sdl_rx u_rx (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .line_i      (pin_s2),
        .enable_i    (locked && txs == sdl_pkg::SDL_IDLE && !in_break),
        .bit_len_i   (bit_len),
        .byte_o      (rx_byte_o),
        .frame_err_o (rx_fe),
        .break_o     (rx_brk)
    );

    assign err_any = rx_fe || coll || (rx_brk && !in_break);

    // ==========================================
    // Transmitter
    logic [`SDL_CNT_W+5:0] ttmr, next_ttmr;
    logic [3:0]            tbit, next_tbit;
    logic [7:0]            tshf, next_tshf;
    logic                  drive_low, next_drive_low;
    logic                  err_brk_pend, next_err_brk_pend;

    always_comb begin
        next_txs          = txs;
        next_ttmr         = ttmr;
        next_tbit         = tbit;
        next_tshf         = tshf;
        next_drive_low    = drive_low;
        next_coll         = 1'b0;
        next_err_brk_pend = err_brk_pend || err_any;
        case (txs)
            sdl_pkg::SDL_IDLE: begin
                next_drive_low = 1'b0;
                if (err_brk_pend) begin
                    // Four characters of low, at last known bit rate
                    next_txs          = sdl_pkg::SDL_BRKTX;
                    next_err_brk_pend = 1'b0;
                    next_drive_low    = 1'b1;
                    next_ttmr = (`SDL_CNT_W+6)'(`SDL_ERR_BREAK_CHARS * `SDL_CHAR_BITS)
                                * {6'h0, bit_len};
                end else if (tx_valid_i && locked && !in_break) begin
                    next_txs       = sdl_pkg::SDL_START;
                    next_tshf      = tx_data_i;
                    next_drive_low = 1'b1;
                    next_ttmr      = {6'h0, bit_len} - 1'b1;
                end
            end
            sdl_pkg::SDL_START: begin
                if (ttmr == 0) begin
                    next_txs       = sdl_pkg::SDL_DATA;
                    next_tbit      = '0;
                    next_drive_low = !tshf[0];
                    next_ttmr      = {6'h0, bit_len} - 1'b1;
                end else begin
                    next_ttmr = ttmr - 1'b1;
                end
            end
            sdl_pkg::SDL_DATA: begin
                // Collision: pin low at centre of a released bit
                if (ttmr == {7'h0, bit_len[`SDL_CNT_W-1:1]} && !drive_low && !pin_s2)
                    next_coll = 1'b1;
                if (ttmr == 0) begin
                    next_ttmr = {6'h0, bit_len} - 1'b1;
                    next_tshf = {1'b0, tshf[7:1]};
                    next_tbit = tbit + 1'b1;
                    if (tbit == 4'd7) begin
                        next_txs       = sdl_pkg::SDL_STOP;
                        next_drive_low = 1'b0;
                        // One and a half stop bits
                        next_ttmr = {6'h0, bit_len} + {7'h0, bit_len[`SDL_CNT_W-1:1]} - 1'b1;
                    end else begin
                        next_drive_low = !tshf[1];
                    end
                end else begin
                    next_ttmr = ttmr - 1'b1;
                end
            end
            sdl_pkg::SDL_STOP: begin
                if (ttmr == {7'h0, bit_len[`SDL_CNT_W-1:1]} && !pin_s2)
                    next_coll = 1'b1;
                if (ttmr == 0)
                    next_txs = sdl_pkg::SDL_IDLE;
                else
                    next_ttmr = ttmr - 1'b1;
            end
            sdl_pkg::SDL_BRKTX: begin
                next_err_brk_pend = 1'b0;
                if (ttmr == 0) begin
                    next_txs       = sdl_pkg::SDL_IDLE;
                    next_drive_low = 1'b0;
                end else begin
                    next_ttmr = ttmr - 1'b1;
                end
            end
            default: begin
                next_txs       = sdl_pkg::SDL_IDLE;
                next_drive_low = 1'b0;
            end
        endcase
        // Any error aborts a character in flight
        if (err_any && txs != sdl_pkg::SDL_BRKTX && txs != sdl_pkg::SDL_IDLE) begin
            next_txs       = sdl_pkg::SDL_IDLE;
            next_drive_low = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_break     <= 1'b0;
            txs          <= sdl_pkg::SDL_IDLE;
            ttmr         <= '0;
            tbit         <= '0;
            tshf         <= '0;
            drive_low    <= 1'b0;
            coll         <= 1'b0;
            err_brk_pend <= 1'b0;
        end else begin
            in_break     <= next_in_break;
            txs          <= next_txs;
            ttmr         <= next_ttmr;
            tbit         <= next_tbit;
            tshf         <= next_tshf;
            drive_low    <= next_drive_low;
            coll         <= next_coll;
            err_brk_pend <= next_err_brk_pend;
        end
    end

    // Open drain: only ever pulls low
    assign debug_serial_pin_o    = 1'b0;
    assign debug_serial_pin_oe_o = drive_low;
    assign tx_ready_o  = txs == sdl_pkg::SDL_IDLE && locked && !in_break && !err_brk_pend;
    assign cmd_abort_o = err_any;
    assign err_o       = '{breakpoint_opcode: rx_brk && !in_break, frame: rx_fe, coll: coll};

    // ==========================================
    // Debug control register and mode
    logic [7:0] ctl, next_ctl;
    logic [1:0] boot, next_boot;
    logic       brk_hit;

    assign brk_hit = cpu_brk_decode_i && cpu_opcode_i == `SDL_BRK_OPCODE;

    always_comb begin
        next_ctl  = ctl;
        next_boot = (boot == 2'h0) ? 2'h0 : boot - 2'h1;
        // Strap read once the synchroniser shows the pin
        if (boot == 2'h1 && !pin_s2)
            next_ctl[`SDL_DBG_BIT] = 1'b1;
        // Break does not touch this register
        if (ctl_we_i)
            next_ctl = ctl_wdata_i;
        if ((brk_hit && ctl[`SDL_BPEN_BIT]) || watch_match_i)
            next_ctl[`SDL_DBG_BIT] = 1'b1;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl  <= 8'h00; // Resets clear debug mode
            boot <= 2'h3;
        end else begin
            ctl  <= next_ctl;
            boot <= next_boot;
        end
    end

    assign ctl_o             = ctl;
    assign debug_mode_flag_o = ctl[`SDL_DBG_BIT];
    // Fetch stops; clocks and peripherals are not gated here
    assign cpu_fetch_stop_o  = ctl[`SDL_DBG_BIT];
    assign halt_exit_o       = ctl[`SDL_DBG_BIT];
    assign wdt_refresh_o     = ctl[`SDL_DBG_BIT];
    assign brk_as_nop_o      = brk_hit && !ctl[`SDL_BPEN_BIT];
    // Raw pin deliberately: synchroniser may not clock in stop mode
    assign sys_reset_req_o   = stop_mode_i && !debug_serial_pin_i;
endmodule // sdl_port

// >>> sdl_port_assertions.sv
// Assertion checker for the single-pin debug port
`timescale 1ns/1ns
module sdl_port_checker (
    // Clock and reset
    input wire logic               clock_i,
    input wire logic               rst_n_i,
    // Debug pin
    input wire logic               debug_serial_pin_i,
    input wire logic               debug_serial_pin_o,
    input wire logic               debug_serial_pin_oe_o,
    // Link side
    input wire sdl_pkg::sdl_byte_t rx_byte_o,
    input wire logic               tx_valid_i,
    input wire logic               tx_ready_o,
    input wire logic               cmd_abort_o,
    input wire sdl_pkg::sdl_err_t  err_o,
    // Control and CPU side
    input wire logic               ctl_we_i,
    input wire logic [7:0]         ctl_wdata_i,
    input wire logic [7:0]         ctl_o,
    input wire logic               cpu_brk_decode_i,
    input wire logic [7:0]         cpu_opcode_i,
    input wire logic               watch_match_i,
    input wire logic               stop_mode_i,
    input wire logic               debug_mode_flag_o,
    input wire logic               cpu_fetch_stop_o,
    input wire logic               brk_as_nop_o,
    input wire logic               halt_exit_o,
    input wire logic               wdt_refresh_o,
    input wire logic               sys_reset_req_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic brk_hit;
    assign brk_hit = cpu_brk_decode_i && (cpu_opcode_i == 8'h00);

    // ==========================================
    // Link
    a_open_drain: assert property (debug_serial_pin_o == 1'b0)
        else $error("pin output not low");
    a_half_duplex: assert property (debug_serial_pin_oe_o |-> !rx_byte_o.valid && !tx_ready_o)
        else $error("receive or accept while sending");
    a_tx_start: assert property (tx_valid_i && tx_ready_o |=> debug_serial_pin_oe_o)
        else $error("no start bit after accept");
    a_err_abort: assert property ((err_o != 3'b000) |-> ##[0:1] cmd_abort_o)
        else $error("error without abort");
    a_err_break: assert property ($rose(cmd_abort_o) |-> ##[1:3] debug_serial_pin_oe_o [*8])
        else $error("no break after error");

    // ==========================================
    // Debug mode control
    a_ctl_set: assert property (ctl_we_i && ctl_wdata_i[0] |=> ctl_o[0])
        else $error("control write did not set debug bit");
    a_brk_enter: assert property (brk_hit && ctl_o[1] |-> ##[1:2] debug_mode_flag_o)
        else $error("enabled breakpoint did not enter debug");
    a_brk_nop: assert property (brk_as_nop_o == (brk_hit && !ctl_o[1]))
        else $error("breakpoint no-op wrong");
    a_watch_enter: assert property (watch_match_i |-> ##[1:2] debug_mode_flag_o)
        else $error("watchpoint did not enter debug");
    a_debug_outs: assert property ({3{debug_mode_flag_o}}
        == {cpu_fetch_stop_o, halt_exit_o, wdt_refresh_o})
        else $error("debug side effects wrong");
    a_stop_reset: assert property (sys_reset_req_o == (stop_mode_i && !debug_serial_pin_i))
        else $error("stop mode reset request wrong");

    c_tx: cover property (tx_valid_i && tx_ready_o);
    c_err: cover property ($rose(cmd_abort_o));
    c_brk: cover property (brk_hit && ctl_o[1]);
    c_stop: cover property (sys_reset_req_o);
endmodule // sdl_port_checker

bind sdl_port sdl_port_checker u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .debug_serial_pin_i(debug_serial_pin_i),
    .debug_serial_pin_o(debug_serial_pin_o), .debug_serial_pin_oe_o(debug_serial_pin_oe_o),
    .rx_byte_o(rx_byte_o), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .cmd_abort_o(cmd_abort_o), .err_o(err_o), .ctl_we_i(ctl_we_i), .ctl_wdata_i(ctl_wdata_i),
    .ctl_o(ctl_o), .cpu_brk_decode_i(cpu_brk_decode_i), .cpu_opcode_i(cpu_opcode_i),
    .watch_match_i(watch_match_i), .stop_mode_i(stop_mode_i),
    .debug_mode_flag_o(debug_mode_flag_o), .cpu_fetch_stop_o(cpu_fetch_stop_o),
    .brk_as_nop_o(brk_as_nop_o), .halt_exit_o(halt_exit_o), .wdt_refresh_o(wdt_refresh_o),
    .sys_reset_req_o(sys_reset_req_o)
);

// >>> sdl_host_model.sv
// Behavioural host serial port on the open-drain debug pin
`timescale 1ns/1ns
module sdl_host_model #(
    parameter int BIT = 16
) (
    // Clock and line
    input  wire logic clock_i,
    input  wire logic line_i,
    // Pull only; the line rises by the pull-up
    output logic      pull_o
);
    initial pull_o = 1'b0;

    // Pull level for n clocks, changed just after a falling edge
    task automatic hold(input logic p, input int n);
        pull_o = p;
        repeat (n) @(negedge clock_i);
    endtask

    // Start, LSB first, 1.5 stop bits at clock over 16
    task automatic send(input logic [7:0] d, input logic stop_ok);
        @(negedge clock_i);
        hold(1'b1, BIT);
        for (int i = 0; i < 8; i++) hold(~d[i], BIT);
        hold(~stop_ok, BIT + BIT / 2);
        pull_o = 1'b0;
    endtask

    // Samples bit centres; unknown result if no start bit shows
    task automatic recv(output logic [7:0] d);
        int t;
        d = 8'hXX;
        t = 0;
        while (line_i !== 1'b0 && t < 100) begin
            @(negedge clock_i);
            t++;
        end
        if (t < 100) begin
            repeat (BIT / 2) @(negedge clock_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(negedge clock_i);
                d[i] = line_i;
            end
        end
    endtask
endmodule // sdl_host_model

// >>> test_single_pin_debug_link.sv
// Self-checking testbench for the single-pin debug port
`timescale 1ns/1ns
module test_single_pin_debug_link;
    typedef struct packed {
        logic       dir;
        logic [7:0] din;
        logic [7:0] dout;
    } sdl_row_t;
    localparam int BIT = 16;
    logic               clock_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic               tx_valid = 1'b0;
    logic [7:0]         tx_data = 8'h00;
    logic               ctl_we = 1'b0;
    logic [7:0]         ctl_wdata = 8'h00;
    logic               brk_dec = 1'b0;
    logic [7:0]         opcode = 8'h00;
    logic               watch = 1'b0;
    logic               stop_mode = 1'b0;
    logic               pin_o, pin_oe, host_pull, tx_ready, abort, flag, fetch, nop;
    logic               halt_exit, wdt_ref, sys_rst, abort_seen, nop_seen;
    logic [7:0]         ctl, got, rx_last;
    logic [2:0]         err_seen = 3'b000;
    sdl_pkg::sdl_byte_t rx_byte;
    sdl_pkg::sdl_err_t  err;
    int                 fails = 0;
    int                 compares = 0;
    int                 rx_cnt = 0;
    // Pull-up wins when nobody pulls
    wire line = (pin_oe ? pin_o : 1'b1) & ~host_pull;
    // Host 00H would look like a break, so host rows avoid it
    sdl_row_t rows [7] = '{'{1'b0, 8'h01, 8'h01}, '{1'b0, 8'hA5, 8'hA5},
        '{1'b0, 8'h80, 8'h80}, '{1'b0, 8'hFE, 8'hFE}, '{1'b1, 8'h00, 8'h00},
        '{1'b1, 8'h5A, 8'h5A}, '{1'b1, 8'hFF, 8'hFF}};

    always #4 clock_i = ~clock_i;

    sdl_port u_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .debug_serial_pin_i(line),
        .debug_serial_pin_o(pin_o), .debug_serial_pin_oe_o(pin_oe), .rx_byte_o(rx_byte),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
        .cmd_abort_o(abort), .ctl_we_i(ctl_we), .ctl_wdata_i(ctl_wdata), .ctl_o(ctl),
        .cpu_brk_decode_i(brk_dec), .cpu_opcode_i(opcode), .watch_match_i(watch),
        .stop_mode_i(stop_mode), .debug_mode_flag_o(flag), .cpu_fetch_stop_o(fetch),
        .brk_as_nop_o(nop), .halt_exit_o(halt_exit), .wdt_refresh_o(wdt_ref),
        .sys_reset_req_o(sys_rst), .err_o(err)
    );
    sdl_host_model #(.BIT(BIT)) u_host (.clock_i(clock_i), .line_i(line), .pull_o(host_pull));

    always @(posedge clock_i) begin
        if (rx_byte.valid === 1'b1) begin
            rx_cnt <= rx_cnt + 1;
            rx_last <= rx_byte.data;
        end
        if (err !== 3'b000) err_seen <= err_seen | err;
        if (abort === 1'b1) abort_seen <= 1'b1;
    end

    // ==========================================
    // Helpers
    task automatic finish_test;
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Waits for oe (sel 0) or tx_ready (sel 1) to reach v
    task automatic wait_for(input logic sel, input logic v, input int lim);
        int t;
        t = 0;
        while (((sel ? tx_ready : pin_oe) !== v) && t < lim) begin
            @(negedge clock_i);
            t++;
        end
        if (t >= lim) begin
            fails++;
            $display("Error wait_%0d expected %b seen timeout", sel, v);
            finish_test;
        end
    endtask

    task automatic dev_send(input logic [7:0] d);
        @(negedge clock_i);
        tx_data = d;
        tx_valid = 1'b1;
        wait_for(1'b1, 1'b1, 300);
        @(negedge clock_i);
        tx_valid = 1'b0;
    endtask

    task automatic ctl_wr(input logic [7:0] d);
        @(negedge clock_i);
        ctl_we = 1'b1;
        ctl_wdata = d;
        @(negedge clock_i);
        ctl_we = 1'b0;
        repeat (2) @(negedge clock_i);
    endtask

    task automatic breakpoint_opcode(input logic [7:0] op);
        @(negedge clock_i);
        brk_dec = 1'b1;
        opcode = op;
        #1 nop_seen = nop;
        @(negedge clock_i);
        brk_dec = 1'b0;
        repeat (2) @(negedge clock_i);
    endtask

    // Measures the error break, then relearns the rate with 80H
    task automatic recover(input logic [2:0] exp_err);
        int n;
        n = 0;
        wait_for(1'b0, 1'b1, 400);
        while (pin_oe === 1'b1 && n < 2000) begin
            @(negedge clock_i);
            n++;
        end
        chk("err_break_len", 1, n >= 40 * (BIT - 1) && n <= 40 * (BIT + 1));
        chk("err_flag", 1, |(err_seen & exp_err));
        chk("cmd_abort", 1, abort_seen);
        chk("ready_unlocked", 0, tx_ready);
        u_host.send(8'h80, 1'b1);
        wait_for(1'b1, 1'b1, 300);
        err_seen = 3'b000;
        abort_seen = 1'b0;
    endtask

    task automatic do_reset(input logic strap);
        @(negedge clock_i);
        rst_n_i = 1'b0;
        u_host.hold(strap, 2);
        rst_n_i = 1'b1;
        u_host.hold(strap, 5);
        u_host.hold(1'b0, 4);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        abort_seen = 1'b0;
        do_reset(1'b0);
        chk("ready_at_reset", 0, tx_ready);
        chk("ctl_at_reset", 0, ctl);
        u_host.send(8'h80, 1'b1);
        wait_for(1'b1, 1'b1, 300);
        for (int i = 0; i < 7; i++) begin
            if (rows[i].dir == 1'b0) begin
                u_host.send(rows[i].din, 1'b1);
                chk("rx_last", rows[i].dout, rx_last);
            end else begin
                fork
                    u_host.recv(got);
                    dev_send(rows[i].din);
                join
                chk("host_got", rows[i].dout, got);
                wait_for(1'b1, 1'b1, 300);
            end
        end
        chk("rx_count", 4, rx_cnt);
        u_host.send(8'hFF, 1'b0);
        recover(3'b010);
        fork
            dev_send(8'hFF);
            begin
                wait_for(1'b0, 1'b1, 300);
                u_host.hold(1'b0, BIT + BIT / 2);
                u_host.hold(1'b1, BIT);
                u_host.hold(1'b0, 1);
            end
        join
        recover(3'b001);
        ctl_wr(8'h01);
        chk("flag_by_write", 1, flag);
        u_host.hold(1'b1, 10 * BIT);
        chk("ready_in_break", 0, tx_ready);
        u_host.hold(1'b0, 1);
        recover(3'b100);
        chk("flag_after_break", 1, flag);
        chk("ctl_after_break", 8'h01, ctl);
        ctl_wr(8'h02);
        chk("flag_cleared", 0, flag);
        breakpoint_opcode(8'h01);
        chk("flag_other_op", 0, flag);
        breakpoint_opcode(8'h00);
        chk("nop_enabled", 0, nop_seen);
        chk("flag_brk", 1, flag);
        chk("fetch_stop", 1, fetch);
        ctl_wr(8'h00);
        breakpoint_opcode(8'h00);
        chk("nop_disabled", 1, nop_seen);
        chk("flag_nop", 0, flag);
        @(negedge clock_i);
        watch = 1'b1;
        @(negedge clock_i);
        watch = 1'b0;
        repeat (2) @(negedge clock_i);
        chk("flag_watch", 1, flag);
        stop_mode = 1'b1;
        u_host.hold(1'b1, 2);
        chk("stop_reset", 1, sys_rst);
        u_host.hold(1'b0, 2);
        chk("stop_no_reset", 0, sys_rst);
        stop_mode = 1'b0;
        do_reset(1'b0);
        chk("flag_after_reset", 0, flag);
        do_reset(1'b1);
        chk("flag_strap", 1, flag);
        finish_test;
    end
endmodule // test_single_pin_debug_link
